// ==== design/motor_drive_protection.sv ====
// protection, stall guard and status outputs of a motor drive
`timescale 1ns/1ps
`include "motor_prot_params.svh"
// Behaviour
// - code 16 asserts output while healthy and waiting for a run command
// - code 17 output follows the fault relay condition mask
// - thermal enabled: trip when current exceeds one-minute level long enough
// - continuous level 50..150 default 100, never above one-minute level
// - cooling type 0 shaft fan derated at low speed, 1 separate fan
// - warning level 30..150 default 150, time 0..30 s default 10
// - code 5 routes the overload warning to the output
// - overload trip after level exceeded for trip time, 30..200, 0..60 s
// - stall mask bit 0 accel, bit 1 constant, bit 2 decel
// - accel stall: hold ramp-up while current exceeds stall level
// - constant stall: decelerate while current exceeds stall level
// - decel stall: pause ramp-down while dc link voltage is high
// - code 7 asserts output while stall prevention acts
// - phase loss enabled: trip when any output phase is open
// - input code 18 normally-open trip, 19 normally-closed, range 0..24
// - normally-open trip input on flags fault and cuts output
// - normally-closed trip input off flags fault and cuts output
// - terminal and relay each select their own status code
// - code 12 asserts output while running and producing voltage
module motor_drive_protection #(
  parameter int unsigned TICKS_PER_SEC = `CLK_HZ,
  parameter int unsigned THERM_SECONDS = `THERM_WINDOW_S
) (
  // clock and reset
  input  wire logic                      clk_sys,
  input  wire logic                      reset_n,
  // configuration
  input  wire motor_prot_pkg::prot_cfg_s cfg,
  input  wire logic [7:0]                motor_rated_current,
  input  wire logic [4:0]                terminal_output_select,
  input  wire logic [4:0]                relay_output_select,
  input  wire logic [2:0]                fault_output_mask,
  input  wire logic [4:0]                input_four_function,
  input  wire logic [4:0]                input_five_function,
  // drive state
  input  wire logic [7:0]                output_current,
  input  wire logic                      low_speed,
  input  wire logic [2:0]                phase_open,
  input  wire logic                      dc_link_high,
  input  wire logic                      undervolt_trip,
  input  wire logic                      auto_restart_set,
  input  wire motor_prot_pkg::ramp_e     ramp_state,
  input  wire logic                      run_command,
  input  wire logic                      fault_clear,
  // external trip terminals
  input  wire logic                      digital_input_four,
  input  wire logic                      digital_input_five,
  // results
  output motor_prot_pkg::trip_s          trip_flags,
  output logic                           output_cut,
  output logic                           overload_warning_item,
  output logic                           stall_active,
  output logic                           ramp_hold,
  output logic                           ramp_force_decel,
  output logic                           status_output_terminal,
  output logic                           status_relay
);
  import motor_prot_pkg::*;

  // ticks per bucket step, worked out wide so the product cannot wrap
  localparam logic [31:0] STEP_TICKS =
    32'(64'(TICKS_PER_SEC) * 64'(THERM_SECONDS) / 64'h0000_0000_0000_0010);

  // current as percent of rated current
  logic [15:0] pct;
  logic [7:0]  one_min_lvl, cont_lvl, base_lvl;
  logic        ext_trip, over_1min, over_warn, over_trip, over_stall;
  logic        warn_exp, trip_exp;
  logic [3:0]  therm_q, therm_d;
  logic [31:0] tick_q, tick_d;
  trip_s       trip_q, trip_d;
  logic        term_q, term_d, relay_q, relay_d;
  logic        warn_q, warn_d;

  // percent of rated current, saturated when rated current is zero
  always_comb begin
    if (motor_rated_current == 8'h00)
      pct = 16'hFFFF;
    else
      pct = 16'((32'(output_current) * 32'd100)
                / 32'(motor_rated_current));
  end

  // clamp levels into range and keep continuous at or under one-minute
  function automatic logic [7:0] clamp8(input logic [7:0] v,
                                        input logic [7:0] lo,
                                        input logic [7:0] hi);
    clamp8 = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clamp8

  always_comb begin
    cont_lvl    = clamp8(cfg.thermal_continuous_level,
                         `THERM_MIN_PCT, `THERM_MAX_PCT);
    one_min_lvl = clamp8(cfg.thermal_one_minute_level,
                         cont_lvl, `THERM_MAX_PCT);
    // shaft-fan motor derates its continuous level at low speed
    base_lvl    = (cfg.motor_cooling_type == 1'b0 && low_speed)
                  ? (cont_lvl >> 1) : cont_lvl;
  end

  // threshold comparisons, each against a clamped level
  assign over_1min  = pct > 16'(one_min_lvl);
  assign over_warn  = pct > 16'(clamp8(cfg.overload_warn_level,
                          `WARN_MIN_PCT, `WARN_MAX_PCT));
  assign over_trip  = pct > 16'(clamp8(cfg.overload_trip_level,
                          `WARN_MIN_PCT, `TRIP_MAX_PCT));
  assign over_stall = pct > 16'(clamp8(cfg.stall_guard_level,
                          `WARN_MIN_PCT, `WARN_MAX_PCT));

  // overload warning and trip persistence timers
  sec_timer #(.TICKS_PER_SEC(TICKS_PER_SEC)) u_warn_timer (
    .clk_sys   (clk_sys),
    .reset_n   (reset_n),
    .active    (over_warn),
    .limit_sec (clamp8(cfg.overload_warn_time, 8'h00,
                       `WARN_TIME_MAX)),
    .expired   (warn_exp)
  );
  sec_timer #(.TICKS_PER_SEC(TICKS_PER_SEC)) u_trip_timer (
    .clk_sys   (clk_sys),
    .reset_n   (reset_n),
    .active    (over_trip && cfg.overload_trip_enable),
    .limit_sec (clamp8(cfg.overload_trip_time, 8'h00,
                       `TRIP_TIME_MAX)),
    .expired   (trip_exp)
  );

  // external trip decode for terminals four and five
  function automatic logic ext_req(input logic [4:0] fn,
                                   input logic       pin);
    ext_req = (fn == `FUNC_TRIP_NO && pin)
           || (fn == `FUNC_TRIP_NC && !pin);
  endfunction : ext_req

  assign ext_trip = ext_req(input_four_function, digital_input_four)
                 || ext_req(input_five_function, digital_input_five);

  // thermal bucket: 16 steps over the one-minute window above level,
  // draining one step per step period at or below the base level
  always_comb begin
    tick_d  = tick_q;
    therm_d = therm_q;
    if (tick_q == STEP_TICKS - 32'h0000_0001) begin
      tick_d = '0;
      if (cfg.thermal_enable && over_1min && therm_q != 4'hF)
        therm_d = therm_q + 4'h1;
      else if (pct <= 16'(base_lvl) && therm_q != 4'h0)
        therm_d = therm_q - 4'h1;
    end else begin
      tick_d = tick_q + 32'h0000_0001;
    end
  end

  // trip latches: set wins over clear
  always_comb begin
    trip_d = trip_q;
    if (fault_clear)
      trip_d = '0;
    if (cfg.thermal_enable && therm_q == 4'hF)
      trip_d.thermal = 1'b1;
    if (trip_exp)
      trip_d.overload = 1'b1;
    if (cfg.phase_loss_enable && |phase_open)
      trip_d.phase_loss = 1'b1;
    if (ext_trip)
      trip_d.external = 1'b1;
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      tick_q  <= '0;
      therm_q <= '0;
      trip_q  <= '0;
    end else begin
      tick_q  <= tick_d;
      therm_q <= therm_d;
      trip_q  <= trip_d;
    end
  end

  assign trip_flags = trip_q;
  assign output_cut = |trip_q;

  // stall guard actions per ramp phase
  always_comb begin
    ramp_hold        = 1'b0;
    ramp_force_decel = 1'b0;
    unique case (ramp_state)
      RAMP_ACCEL: ramp_hold = cfg.stall_guard_mask[`MASK_ACCEL]
                              && over_stall;
      RAMP_CONST: ramp_force_decel = cfg.stall_guard_mask[`MASK_CONST]
                              && over_stall;
      RAMP_DECEL: ramp_hold = cfg.stall_guard_mask[`MASK_DECEL]
                              && dc_link_high;
      RAMP_HOLD:  ramp_hold = 1'b0;
    endcase
  end
  assign stall_active = ramp_hold || ramp_force_decel;

  // status selection shared by terminal and relay
  function automatic logic status_sel(input logic [4:0] code,
                                      input logic       warn,
                                      input logic       stall,
                                      input logic       run,
                                      input logic       cut,
                                      input logic       fault_rel,
                                      input ramp_e      rs);
    unique case (code)
      `SEL_WARN:        status_sel = warn;
      `SEL_STALL:       status_sel = stall;
      `SEL_RUN:         status_sel = run && !cut;
      `SEL_STOP:        status_sel = !run || cut;
      `SEL_CONST:       status_sel = run && !cut && rs == RAMP_CONST;
      `SEL_WAIT_RUN:    status_sel = !run && !cut;
      `SEL_FAULT_RELAY: status_sel = fault_rel;
      default:          status_sel = 1'b0;
    endcase
  endfunction : status_sel

  // registered outputs; relay condition mask bit 0 undervolt,
  // bit 1 other trips, bit 2 auto restart configured
  always_comb begin
    logic fault_rel;
    fault_rel = (fault_output_mask[0] && undervolt_trip)
             || (fault_output_mask[1] && output_cut)
             || (fault_output_mask[2] && auto_restart_set
                 && (output_cut || undervolt_trip));
    warn_d  = warn_exp;
    term_d  = status_sel(terminal_output_select, warn_q, stall_active,
                         run_command, output_cut, fault_rel,
                         ramp_state);
    relay_d = status_sel(relay_output_select, warn_q, stall_active,
                         run_command, output_cut, fault_rel,
                         ramp_state);
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      warn_q  <= 1'b0;
      term_q  <= 1'b0;
      relay_q <= 1'b0;
    end else begin
      warn_q  <= warn_d;
      term_q  <= term_d;
      relay_q <= relay_d;
    end
  end

  assign overload_warning_item  = warn_q;
  assign status_output_terminal = term_q;
  assign status_relay           = relay_q;

  // assertions
  sequence s_ext_seen;
    ext_trip;
  endsequence

  property p_ext_trip;
    @(posedge clk_sys) disable iff (!reset_n)
      s_ext_seen |=> trip_q.external && output_cut;
  endproperty
  a_ext_trip: assert property (p_ext_trip)
    else $error("external trip not latched");

  property p_nc_trip;
    @(posedge clk_sys) disable iff (!reset_n)
      (input_five_function == `FUNC_TRIP_NC && !digital_input_five)
        |=> output_cut;
  endproperty
  a_nc_trip: assert property (p_nc_trip)
    else $error("normally closed trip ignored");

  property p_phase;
    @(posedge clk_sys) disable iff (!reset_n)
      (cfg.phase_loss_enable && |phase_open) |=> trip_q.phase_loss;
  endproperty
  a_phase: assert property (p_phase)
    else $error("phase loss not latched");

  property p_latch;
    @(posedge clk_sys) disable iff (!reset_n)
      (output_cut && !fault_clear) |=> output_cut;
  endproperty
  a_latch: assert property (p_latch)
    else $error("trip released without clear");

  property p_accel;
    @(posedge clk_sys) disable iff (!reset_n)
      (ramp_state == RAMP_ACCEL && cfg.stall_guard_mask[0]
       && over_stall) |-> ramp_hold && !ramp_force_decel;
  endproperty
  a_accel: assert property (p_accel)
    else $error("accel stall hold missing");

  property p_const;
    @(posedge clk_sys) disable iff (!reset_n)
      (ramp_state == RAMP_CONST) |->
        ramp_force_decel == (cfg.stall_guard_mask[1] && over_stall);
  endproperty
  a_const: assert property (p_const)
    else $error("constant speed stall wrong");

  property p_decel;
    @(posedge clk_sys) disable iff (!reset_n)
      (ramp_state == RAMP_DECEL) |->
        ramp_hold == (cfg.stall_guard_mask[2] && dc_link_high);
  endproperty
  a_decel: assert property (p_decel)
    else $error("decel stall wrong");

  property p_stall_out;
    @(posedge clk_sys) disable iff (!reset_n)
      (terminal_output_select == `SEL_STALL && stall_active)
        |=> status_output_terminal;
  endproperty
  a_stall_out: assert property (p_stall_out)
    else $error("stall status not shown");

  property p_wait_run;
    @(posedge clk_sys) disable iff (!reset_n)
      (relay_output_select == `SEL_WAIT_RUN) |=>
        status_relay == (!$past(run_command) && !$past(output_cut));
  endproperty
  a_wait_run: assert property (p_wait_run)
    else $error("wait for run status wrong");

  property p_run;
    @(posedge clk_sys) disable iff (!reset_n)
      (terminal_output_select == `SEL_RUN && run_command && !output_cut)
        |=> status_output_terminal;
  endproperty
  a_run: assert property (p_run)
    else $error("during run status missing");
endmodule : motor_drive_protection

// ==== design/motor_prot_params.svh ====
// constants of the motor drive protection block
`ifndef MOTOR_PROT_PARAMS_SVH
`define MOTOR_PROT_PARAMS_SVH
`define SEL_WARN           5'h05
`define SEL_STALL          5'h07
`define SEL_RUN            5'h0C
`define SEL_STOP           5'h0D
`define SEL_CONST          5'h0E
`define SEL_WAIT_RUN       5'h10
`define SEL_FAULT_RELAY    5'h11
`define FUNC_TRIP_NO       5'h12
`define FUNC_TRIP_NC       5'h13
`define FUNC_MAX           5'h18
`define THERM_MIN_PCT      8'h32
`define THERM_MAX_PCT      8'h96
`define THERM_1M_DEF       8'h96
`define THERM_CONT_DEF     8'h64
`define WARN_MIN_PCT       8'h1E
`define WARN_MAX_PCT       8'h96
`define TRIP_MAX_PCT       8'hC8
`define WARN_TIME_MAX      8'h1E
`define TRIP_TIME_MAX      8'h3C
`define STALL_MASK_DEF     3'h3
`define MASK_ACCEL         0
`define MASK_CONST         1
`define MASK_DECEL         2
`define CLK_HZ             200000000
`define THERM_WINDOW_S     60
`endif

// ==== design/motor_prot_pkg.sv ====
// types of the motor drive protection block
package motor_prot_pkg;
  typedef enum logic [1:0] {
    RAMP_HOLD  = 2'b00,
    RAMP_ACCEL = 2'b01,
    RAMP_CONST = 2'b10,
    RAMP_DECEL = 2'b11
  } ramp_e;
  typedef struct packed {
    logic thermal;
    logic overload;
    logic phase_loss;
    logic external;
  } trip_s;
  typedef struct packed {
    logic       thermal_enable;
    logic [7:0] thermal_one_minute_level;
    logic [7:0] thermal_continuous_level;
    logic       motor_cooling_type;
    logic [7:0] overload_warn_level;
    logic [7:0] overload_warn_time;
    logic       overload_trip_enable;
    logic [7:0] overload_trip_level;
    logic [7:0] overload_trip_time;
    logic [2:0] stall_guard_mask;
    logic [7:0] stall_guard_level;
    logic       phase_loss_enable;
  } prot_cfg_s;
endpackage : motor_prot_pkg

// ==== design/sec_timer.sv ====
// per-second persistence timer: counts seconds while a condition holds
`timescale 1ns/1ps
module sec_timer #(
  parameter int unsigned TICKS_PER_SEC = 200000000
) (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  // condition and limit
  input  wire logic       active,
  input  wire logic [7:0] limit_sec,
  // result
  output logic            expired
);
  logic [31:0] tick_q, tick_d;
  logic [7:0]  sec_q, sec_d;

  // prescaler and seconds counter, cleared when the condition drops
  always_comb begin
    tick_d = tick_q;
    sec_d  = sec_q;
    if (!active) begin
      tick_d = '0;
      sec_d  = '0;
    end else if (sec_q < limit_sec) begin
      if (tick_q == TICKS_PER_SEC - 1) begin
        tick_d = '0;
        sec_d  = sec_q + 8'h01;
      end else begin
        tick_d = tick_q + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      tick_q <= '0;
      sec_q  <= '0;
    end else begin
      tick_q <= tick_d;
      sec_q  <= sec_d;
    end
  end

  // zero limit expires as soon as the condition holds
  assign expired = active && (sec_q >= limit_sec);
endmodule : sec_timer

// ==== bench/ext_sequence_model.sv ====
// external control sequence: run command and external trip contacts
`timescale 1ns/1ps
module ext_sequence_model (
  // clock
  input  wire logic       clk_sys,
  // requests from the bench
  input  wire logic       req_run,
  input  wire logic       req_trip_no,
  input  wire logic       req_trip_nc,
  input  wire logic [1:0] lag,
  // contacts toward the drive
  output logic            run_command,
  output logic            digital_input_four,
  output logic            digital_input_five
);
  logic [3:0] pipe_run;
  logic [3:0] pipe_no;
  logic [3:0] pipe_nc;

  // contacts start idle: normally-closed contact held on
  initial begin
    pipe_run = 4'h0;
    pipe_no = 4'h0;
    pipe_nc = 4'h0;
    run_command = 1'b0;
    digital_input_four = 1'b0;
    digital_input_five = 1'b1;
  end

  // requests pass a short pipe so the sequence can answer slowly
  always @(posedge clk_sys) begin
    pipe_run <= {pipe_run[2:0], req_run};
    pipe_no  <= {pipe_no[2:0], req_trip_no};
    pipe_nc  <= {pipe_nc[2:0], req_trip_nc};
  end

  // contacts change only after a falling edge
  always @(negedge clk_sys) begin
    run_command        <= pipe_run[lag];
    digital_input_four <= pipe_no[lag];
    digital_input_five <= !pipe_nc[lag];
  end
endmodule : ext_sequence_model

// ==== bench/motor_drive_protection_bench.sv ====
// self-checking bench of the motor drive protection block
`timescale 1ns/1ps
`include "motor_prot_params.svh"
module motor_drive_protection_bench;
  import motor_prot_pkg::*;
  localparam int unsigned TPS = 16;
  // clock, reset and drive inputs
  logic        clk_sys = 1'b0;
  logic        reset_n = 1'b0;
  prot_cfg_s   cfg;
  logic [7:0]  motor_rated_current, output_current;
  logic [4:0]  terminal_output_select, relay_output_select;
  logic [4:0]  input_four_function, input_five_function;
  logic [2:0]  fault_output_mask, phase_open;
  logic        low_speed, dc_link_high, undervolt_trip;
  logic        auto_restart_set, fault_clear;
  ramp_e       ramp_state;
  logic        req_run, req_trip_no, req_trip_nc;
  logic [1:0]  lag;
  logic        run_command, digital_input_four, digital_input_five;
  // design results and bookkeeping
  trip_s       trip_flags;
  logic        output_cut, overload_warning_item, stall_active;
  logic        ramp_hold, ramp_force_decel;
  logic        status_output_terminal, status_relay;
  logic [10:0] obs, e, m;
  logic [10:0] exp_q[$], msk_q[$];
  logic        h, d, over, t;
  int          failures = 0;
  int          compares = 0;
  int          codes[4] = '{12, 13, 14, 16};
  event        look;

  assign obs = {trip_flags, output_cut, overload_warning_item, stall_active,
                ramp_hold, ramp_force_decel, status_output_terminal,
                status_relay};

  // clock at 200 MHz
  always #2.5 clk_sys = ~clk_sys;

  motor_drive_protection #(.TICKS_PER_SEC(TPS), .THERM_SECONDS(1)) u_dut (
    .clk_sys(clk_sys), .reset_n(reset_n), .cfg(cfg),
    .motor_rated_current(motor_rated_current),
    .terminal_output_select(terminal_output_select),
    .relay_output_select(relay_output_select),
    .fault_output_mask(fault_output_mask),
    .input_four_function(input_four_function),
    .input_five_function(input_five_function),
    .output_current(output_current), .low_speed(low_speed),
    .phase_open(phase_open), .dc_link_high(dc_link_high),
    .undervolt_trip(undervolt_trip), .auto_restart_set(auto_restart_set),
    .ramp_state(ramp_state), .run_command(run_command),
    .fault_clear(fault_clear), .digital_input_four(digital_input_four),
    .digital_input_five(digital_input_five), .trip_flags(trip_flags),
    .output_cut(output_cut), .overload_warning_item(overload_warning_item),
    .stall_active(stall_active), .ramp_hold(ramp_hold),
    .ramp_force_decel(ramp_force_decel),
    .status_output_terminal(status_output_terminal),
    .status_relay(status_relay));

  ext_sequence_model u_seq (
    .clk_sys(clk_sys), .req_run(req_run), .req_trip_no(req_trip_no),
    .req_trip_nc(req_trip_nc), .lag(lag), .run_command(run_command),
    .digital_input_four(digital_input_four),
    .digital_input_five(digital_input_five));

  // prints the counts and the verdict, then stops
  task automatic close_out();
    $display("failures=%0d compares=%0d", failures, compares);
    if (failures == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out

  // notes an expectation for the next rising edge
  task automatic chk(input logic [10:0] mk, input logic [10:0] v);
    @(posedge clk_sys);
    #1;
    msk_q.push_back(mk);
    exp_q.push_back(v);
    -> look;
    @(negedge clk_sys);
  endtask : chk

  // waits, bounded, for an output bit to rise no sooner than lo cycles
  task automatic rise(input int b, input int lo, input int hi);
    int n;
    n = 0;
    while (obs[b] !== 1'b1 && n < hi) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    compares++;
    if (n < lo || obs[b] !== 1'b1) begin
      $display("CHECK FAILED at %0t: bit %0d after %0d cycles", $time, b, n);
      failures++;
    end
    if (obs[b] !== 1'b1) begin
      close_out();
    end else begin
      @(negedge clk_sys);
    end
  endtask : rise

  // removes every cause, pulses the clear and expects no trip
  task automatic clr();
    output_current = 8'h00;
    phase_open = 3'h0;
    req_trip_no = 1'b0;
    req_trip_nc = 1'b0;
    repeat (3) @(negedge clk_sys);
    fault_clear = 1'b1;
    @(negedge clk_sys);
    fault_clear = 1'b0;
    chk(11'h7C0, 11'h000);
  endtask : clr

  // compares the oldest note with the outputs
  always @(look) begin
    e = exp_q.pop_front();
    m = msk_q.pop_front();
    compares++;
    if (((obs ^ e) & m) !== 11'h000) begin
      $display("CHECK FAILED at %0t: saw %h wanted %h", $time, obs & m, e);
      failures++;
    end
  end

  // a hang is cut short here
  initial begin
    #400000;
    failures++;
    $display("CHECK FAILED at %0t: run too long", $time);
    close_out();
  end

  // main sequence
  initial begin
    void'($urandom(61045));
    cfg = '0;
    cfg.thermal_one_minute_level = 8'h96;
    cfg.thermal_continuous_level = 8'h64;
    cfg.overload_warn_level = 8'h96;
    cfg.overload_warn_time = 8'h0A;
    motor_rated_current = 8'h64;
    output_current = 8'h00;
    terminal_output_select = 5'h00;
    relay_output_select = 5'h00;
    input_four_function = `FUNC_TRIP_NO;
    input_five_function = `FUNC_TRIP_NC;
    fault_output_mask = 3'h0;
    phase_open = 3'h0;
    {low_speed, dc_link_high, undervolt_trip} = 3'h0;
    {auto_restart_set, fault_clear} = 2'h0;
    ramp_state = RAMP_HOLD;
    {req_run, req_trip_no, req_trip_nc} = 3'h0;
    lag = 2'h0;
    repeat (6) @(negedge clk_sys);
    reset_n = 1'b1;
    chk(11'h7FF, 11'h000);
    // fault relay mask, wait-for-run and the normally-open trip
    terminal_output_select = `SEL_FAULT_RELAY;
    relay_output_select = `SEL_WAIT_RUN;
    fault_output_mask = 3'h1;
    undervolt_trip = 1'b1;
    chk(11'h003, 11'h003);
    undervolt_trip = 1'b0;
    fault_output_mask = 3'h2;
    chk(11'h003, 11'h001);
    req_trip_no = 1'b1;
    @(negedge clk_sys);
    chk(11'h0C0, 11'h0C0);
    chk(11'h003, 11'h002);
    req_trip_no = 1'b0;
    repeat (2) @(negedge clk_sys);
    chk(11'h0C0, 11'h0C0);
    clr();
    // slow sequence drops the normally-closed contact
    lag = 2'h2;
    req_trip_nc = 1'b1;
    repeat (2) @(negedge clk_sys);
    chk(11'h0C0, 11'h000);
    chk(11'h0C0, 11'h0C0);
    lag = 2'h0;
    clr();
    // other input function ignores the contact
    input_four_function = 5'h05;
    req_trip_no = 1'b1;
    repeat (3) @(negedge clk_sys);
    chk(11'h0C0, 11'h000);
    clr();
    input_four_function = `FUNC_TRIP_NO;
    // phase loss disabled, then each phase open
    phase_open = 3'h7;
    chk(11'h140, 11'h000);
    cfg.phase_loss_enable = 1'b1;
    for (int i = 0; i < 3; i++) begin
      phase_open = 3'h1 << i;
      chk(11'h140, 11'h140);
      clr();
    end
    // stall guard with random mode, mask, link voltage and current
    relay_output_select = `SEL_STALL;
    terminal_output_select = `SEL_STALL;
    cfg.stall_guard_level = 8'h78;
    for (int i = 0; i < 48; i++) begin
      cfg.stall_guard_mask = 3'($urandom_range(7));
      ramp_state = ramp_e'($urandom_range(3));
      dc_link_high = 1'($urandom_range(1));
      output_current = 8'(110 + $urandom_range(20));
      over = output_current > cfg.stall_guard_level;
      h = (ramp_state == RAMP_ACCEL && cfg.stall_guard_mask[0] && over)
        || (ramp_state == RAMP_DECEL && cfg.stall_guard_mask[2]
            && dc_link_high);
      d = ramp_state == RAMP_CONST && cfg.stall_guard_mask[1] && over;
      chk(11'h01F, {6'h0, h|d, h, d, h|d, h|d});
    end
    // scaling by rated current at the stall boundary
    motor_rated_current = 8'hC8;
    cfg.stall_guard_mask = 3'h1;
    ramp_state = RAMP_ACCEL;
    output_current = 8'hF0;
    chk(11'h008, 11'h000);
    output_current = 8'hF2;
    chk(11'h008, 11'h008);
    motor_rated_current = 8'h64;
    output_current = 8'h00;
    cfg.stall_guard_mask = 3'h0;
    dc_link_high = 1'b0;
    // run, stop, constant and wait codes on the terminal
    ramp_state = RAMP_CONST;
    relay_output_select = `SEL_STOP;
    for (int r = 0; r < 2; r++) begin
      req_run = r[0];
      repeat (2) @(negedge clk_sys);
      foreach (codes[k]) begin
        terminal_output_select = 5'(codes[k]);
        t = (codes[k] == 12 || codes[k] == 14) ? r[0] : !r[0];
        chk(11'h003, {9'h000, t, !r[0]});
      end
    end
    req_run = 1'b0;
    // overload warning routed to the terminal
    terminal_output_select = `SEL_WARN;
    cfg.overload_warn_level = 8'h78;
    cfg.overload_warn_time = 8'h01;
    output_current = 8'h79;
    rise(1, 14, 24);
    chk(11'h020, 11'h020);
    // overload trip: at the level, above it, and with zero time
    cfg.overload_trip_enable = 1'b1;
    cfg.overload_trip_level = 8'hB4;
    cfg.overload_trip_time = 8'h02;
    output_current = 8'hB4;
    repeat (40) @(negedge clk_sys);
    chk(11'h200, 11'h000);
    output_current = 8'hB5;
    rise(9, 30, 40);
    clr();
    cfg.overload_trip_time = 8'h00;
    output_current = 8'hC8;
    rise(9, 1, 4);
    clr();
    cfg.overload_trip_enable = 1'b0;
    // thermal cut-off above the one-minute level
    cfg.thermal_enable = 1'b1;
    cfg.motor_cooling_type = 1'b1;
    // one-minute level set under continuous is lifted to it
    cfg.thermal_one_minute_level = 8'h32;
    output_current = 8'h5A;
    repeat (20) @(negedge clk_sys);
    chk(11'h400, 11'h000);
    cfg.thermal_one_minute_level = 8'h96;
    output_current = 8'hA0;
    rise(10, 8, 60);
    chk(11'h040, 11'h040);
    // shaft-fan motor at low speed holds heat, full speed drains it
    cfg.motor_cooling_type = 1'b0;
    low_speed = 1'b1;
    output_current = 8'h4B;
    for (int s = 0; s < 2; s++) begin
      repeat (20) @(negedge clk_sys);
      fault_clear = 1'b1;
      @(negedge clk_sys);
      fault_clear = 1'b0;
      chk(11'h400, {!s[0], 10'h000});
      low_speed = 1'b0;
    end
    close_out();
  end
endmodule : motor_drive_protection_bench
